// *** src/acs_defines.vh ***
// Purpose: constants for the conversion sequencer
// Assumes: classic wishbone, 32-bit data, byte addresses
// Notes: register offsets are word aligned
//
// Behaviour
// - software-start mode: a start write launches one conversion of selected channel
// - on finish store result, set done flag, pulse irq together
// - start bit clears itself once conversion has started
// - repeat mode: each finished conversion immediately launches the next
// - writing disable mode halts conversion; partial value not stored
// - conversion completes only after selected time in system clocks
// - reading the upper result register clears the done flag
// - new start clears done flag; old result kept until new completes
// - standby aborts conversion, resets control registers, result lost
// - after standby stay idle until reprogrammed and restarted
// - standby disconnects reference ladder regardless of ladder setting
// - each conversion yields a 10-bit unsigned code
// - upper eight bits in upper register, low two in status register
// - time codes 000,010..110 give 39..1248 clocks; 001,111 reserved
// - done flag cleared by reading the upper result register
// - channel codes 0000..0111 pick inputs 0..7, others reserved
// - busy flag high during conversion, cleared on standby
`ifndef ACS_DEFINES_VH
`define ACS_DEFINES_VH

// ----------------------------------------
// register byte offsets
// ----------------------------------------
`define ACS_OFF_CTRL1 4'h0
`define ACS_OFF_CTRL2 4'h4
`define ACS_OFF_RES_UP 4'h8
`define ACS_OFF_RES_LOW 4'hc

// ----------------------------------------
// fields
// ----------------------------------------
`define ACS_C1_START 7
`define ACS_C1_MODE_HI 6
`define ACS_C1_MODE_LO 5
`define ACS_C1_AIN_OFF 4
`define ACS_C2_LADDER 5
`define ACS_ST_DONE 5
`define ACS_ST_BUSY 4

// ----------------------------------------
// reset values and codes
// ----------------------------------------
`define ACS_C1_RESET 8'h10
`define ACS_C2_RESET 8'h10
`define ACS_C2_WMASK 8'h2e
`define ACS_MODE_OFF 2'h0
`define ACS_MODE_SW 2'h1
`define ACS_MODE_REP 2'h3

// ----------------------------------------
// conversion times in system clocks
// ----------------------------------------
`define ACS_T0 11'h027
`define ACS_T2 11'h04e
`define ACS_T3 11'h09c
`define ACS_T4 11'h138
`define ACS_T5 11'h270
`define ACS_T6 11'h4e0

`endif

// *** src/acs_sequencer.v ***
// Purpose: sequencer for a 10-bit converter, wishbone registers
// Assumes: analog front end gives its code on adc_code at countdown end
// Notes: ack comes one cycle after the request, single-cycle pulse
`timescale 1ns/10ps
`default_nettype none
`include "acs_defines.vh"
module acs_sequencer #(
    parameter CODE_W = 10
) (
    // clock and reset
    input wire clk_sys,
    input wire resetn,
    // wishbone slave
    input wire wb_cyc_i,
    input wire wb_stb_i,
    input wire wb_we_i,
    input wire [3:0] wb_adr_i,
    input wire [3:0] wb_sel_i,
    input wire [31:0] wb_dat_i,
    output reg [31:0] wb_dat_o,
    output reg wb_ack_o,
    // power state
    input wire standby,
    // analog front end
    input wire [CODE_W-1:0] adc_code,
    output reg [2:0] channel_sel_reg,
    output reg analog_input_off_reg,
    output reg ladder_on_reg,
    output reg sample_reg,
    // events
    output reg conv_done_irq
);
    // ----------------------------------------
    // state
    // ----------------------------------------
    localparam ST_IDLE = 1'b0;
    localparam ST_CONV = 1'b1;

    reg state_reg;
    reg [7:0] ctrl1_reg;
    reg [7:0] ctrl2_reg;
    reg [CODE_W-1:0] result_reg;
    reg done_reg;
    reg busy_reg;
    reg load_reg;

    wire [1:0] mode = ctrl1_reg[`ACS_C1_MODE_HI:`ACS_C1_MODE_LO];
    wire mode_ok = (mode == `ACS_MODE_SW) || (mode == `ACS_MODE_REP);
    wire expire;

    // ----------------------------------------
    // bus decode
    // ----------------------------------------
    wire req = wb_cyc_i && wb_stb_i && !wb_ack_o;
    wire wr = req && wb_we_i && wb_sel_i[0];
    wire rd = req && !wb_we_i;
    wire wr_c1 = wr && (wb_adr_i == `ACS_OFF_CTRL1);
    wire wr_c2 = wr && (wb_adr_i == `ACS_OFF_CTRL2);
    wire rd_up = rd && (wb_adr_i == `ACS_OFF_RES_UP);
    wire [7:0] c1_wdat = wb_dat_i[7:0];
    wire start_req = wr_c1 && c1_wdat[`ACS_C1_START] &&
        ((c1_wdat[6:5] == `ACS_MODE_SW) || (c1_wdat[6:5] == `ACS_MODE_REP));
    wire halt_req = wr_c1 && (c1_wdat[6:5] == `ACS_MODE_OFF);
    wire abort = standby || halt_req;

    acs_timer #(
        .WIDTH(11)
    ) u_timer (
        .clk_sys(clk_sys),
        .resetn(resetn),
        .load(load_reg),
        .abort(abort),
        .time_sel(ctrl2_reg[3:1]),
        .expire_reg(expire)
    );

    // ----------------------------------------
    // wishbone answer
    // ----------------------------------------
    always @(posedge clk_sys) begin
        if (!resetn) begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= 32'h0;
        end else begin
            wb_ack_o <= req;
            wb_dat_o <= 32'h0;
            if (rd) begin
                case (wb_adr_i)
                    `ACS_OFF_CTRL1: wb_dat_o <= {24'h0, ctrl1_reg};
                    `ACS_OFF_CTRL2: wb_dat_o <= {24'h0, 2'h0, ctrl2_reg[5:0]};
                    `ACS_OFF_RES_UP: wb_dat_o <= {24'h0, result_reg[9:2]};
                    `ACS_OFF_RES_LOW: wb_dat_o <= {24'h0, result_reg[1:0],
                        done_reg, busy_reg, 4'h0};
                    // unmapped reads answer zero
                    default: wb_dat_o <= 32'h0;
                endcase
            end
        end
    end

    // ----------------------------------------
    // control registers
    // ----------------------------------------
    always @(posedge clk_sys) begin
        if (!resetn || standby) begin
            ctrl1_reg <= `ACS_C1_RESET;
            ctrl2_reg <= `ACS_C2_RESET;
        end else begin
            if (wr_c1)
                ctrl1_reg <= c1_wdat;
            else if (load_reg)
                ctrl1_reg[`ACS_C1_START] <= 1'b0;
            else if (!mode_ok)
                ctrl1_reg[`ACS_C1_START] <= 1'b0;
            if (wr_c2)
                ctrl2_reg <= (wb_dat_i[7:0] & `ACS_C2_WMASK) | `ACS_C2_RESET;
        end
    end

    // ----------------------------------------
    // sequencer
    // ----------------------------------------
    always @(posedge clk_sys) begin
        if (!resetn || standby) begin
            state_reg <= ST_IDLE;
            busy_reg <= 1'b0;
            load_reg <= 1'b0;
            done_reg <= 1'b0;
            conv_done_irq <= 1'b0;
            sample_reg <= 1'b0;
            result_reg <= {CODE_W{1'b0}};
        end else begin
            load_reg <= 1'b0;
            conv_done_irq <= 1'b0;
            sample_reg <= 1'b0;
            if (rd_up)
                done_reg <= 1'b0;
            case (state_reg)
                ST_IDLE: begin
                    if (start_req) begin
                        state_reg <= ST_CONV;
                        busy_reg <= 1'b1;
                        load_reg <= 1'b1;
                        done_reg <= 1'b0;
                    end
                end
                ST_CONV: begin
                    if (halt_req) begin
                        state_reg <= ST_IDLE;
                        busy_reg <= 1'b0;
                    end else if (expire) begin
                        result_reg <= adc_code;
                        sample_reg <= 1'b1;
                        done_reg <= 1'b1;
                        conv_done_irq <= 1'b1;
                        if (mode == `ACS_MODE_REP) begin
                            load_reg <= 1'b1;
                        end else begin
                            state_reg <= ST_IDLE;
                            busy_reg <= 1'b0;
                        end
                    end
                end
                default: state_reg <= ST_IDLE;
            endcase
        end
    end

    // ----------------------------------------
    // front-end controls
    // ----------------------------------------
    always @(posedge clk_sys) begin
        if (!resetn || standby) begin
            channel_sel_reg <= 3'h0;
            analog_input_off_reg <= 1'b1;
            ladder_on_reg <= 1'b0;
        end else begin
            if (!ctrl1_reg[3])
                channel_sel_reg <= ctrl1_reg[2:0];
            analog_input_off_reg <= ctrl1_reg[`ACS_C1_AIN_OFF];
            ladder_on_reg <= ctrl2_reg[`ACS_C2_LADDER] || busy_reg;
        end
    end
endmodule
`default_nettype wire

// *** src/acs_timer.v ***
// Purpose: conversion-time countdown
// Assumes: load is a single-cycle request; abort stays high while standby is held
// Notes: expire pulses one cycle when count ends
`timescale 1ns/10ps
`default_nettype none
`include "acs_defines.vh"
module acs_timer #(
    parameter WIDTH = 11
) (
    // clock and reset
    input wire clk_sys,
    input wire resetn,
    // control
    input wire load,
    input wire abort,
    input wire [2:0] time_sel,
    // status
    output reg expire_reg
);
    reg [WIDTH-1:0] count_reg;
    reg run_reg;
    reg [WIDTH-1:0] load_val;

    always @* begin
        case (time_sel)
            3'h0: load_val = `ACS_T0;
            3'h2: load_val = `ACS_T2;
            3'h3: load_val = `ACS_T3;
            3'h4: load_val = `ACS_T4;
            3'h5: load_val = `ACS_T5;
            3'h6: load_val = `ACS_T6;
            // reserved codes fall back to the longest time
            default: load_val = `ACS_T6;
        endcase
    end

    always @(posedge clk_sys) begin
        if (!resetn || abort) begin
            count_reg <= {WIDTH{1'b0}};
            run_reg <= 1'b0;
            expire_reg <= 1'b0;
        end else if (load) begin
            count_reg <= load_val - 1'b1;
            run_reg <= 1'b1;
            expire_reg <= 1'b0;
        end else if (run_reg) begin
            expire_reg <= (count_reg == {{(WIDTH-1){1'b0}}, 1'b1});
            if (count_reg == {{(WIDTH-1){1'b0}}, 1'b1})
                run_reg <= 1'b0;
            count_reg <= count_reg - 1'b1;
        end else begin
            expire_reg <= 1'b0;
        end
    end
endmodule
`default_nettype wire

// *** verification/acs_analog_model.sv ***
// Purpose: eight analog channels behind the front end
// Assumes: levels set by the bench before a start
// Notes: a disabled input shows a changing pattern, not a held level
`timescale 1ns/10ps
`default_nettype none
module acs_analog_model (
    // clock
    input wire logic clk_sys,
    // selection
    input wire logic [2:0] channel_sel_reg,
    input wire logic analog_input_off_reg,
    // code out
    output var logic [9:0] adc_code
);
    logic [9:0] level_mem [0:7];
    logic [9:0] noise_reg = 10'h155;
    task set_level(input logic [2:0] c, input logic [9:0] v);
        level_mem[c] = v;
    endtask
    always @(posedge clk_sys) noise_reg <= ~noise_reg;
    always_comb adc_code = analog_input_off_reg ? noise_reg : level_mem[channel_sel_reg];
endmodule
`default_nettype wire

// *** verification/acs_sequencer_chk.sv ***
// Purpose: port checks for the conversion sequencer
// Assumes: one clock, synchronous active-low reset
// Notes: bound from the bench top
`timescale 1ns/10ps
`default_nettype none
module acs_sequencer_chk (
    // clock and reset
    input wire logic clk_sys,
    input wire logic resetn,
    // bus
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic [31:0] wb_dat_o,
    input wire logic wb_ack_o,
    // power and front end
    input wire logic standby,
    input wire logic [2:0] channel_sel_reg,
    input wire logic analog_input_off_reg,
    input wire logic ladder_on_reg,
    input wire logic sample_reg,
    input wire logic conv_done_irq
);
    logic [10:0] gap_reg;
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!resetn);
    // cycles since the last completion, saturating
    always_ff @(posedge clk_sys) begin
        if (!resetn || conv_done_irq) gap_reg <= 11'h0;
        else if (gap_reg != 11'h7ff) gap_reg <= gap_reg + 11'h1;
    end
    AST_ACK_NEXT: assert property (
        wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o) else $error("no ack");
    AST_ACK_PULSE: assert property (
        wb_ack_o |=> !wb_ack_o) else $error("ack held");
    AST_DAT_NARROW: assert property (
        wb_ack_o |-> wb_dat_o[31:8] == 24'h0) else $error("wide data");
    AST_IRQ_PULSE: assert property (
        conv_done_irq |=> !conv_done_irq) else $error("irq held");
    AST_IRQ_GAP: assert property (
        conv_done_irq |-> gap_reg >= 11'd38) else $error("short conversion");
    AST_IRQ_SAMPLED: assert property (
        conv_done_irq |-> sample_reg || $past(sample_reg) || $past(sample_reg, 2))
        else $error("irq without sample");
    AST_STBY_LADDER: assert property (
        standby ##1 standby |-> !ladder_on_reg && !conv_done_irq)
        else $error("ladder on in standby");
    AST_STBY_CTRL: assert property (
        standby ##1 standby |-> analog_input_off_reg && channel_sel_reg == 3'h0)
        else $error("control not reset");
    AST_STBY_QUIET: assert property (
        $fell(standby) |-> !conv_done_irq [*8]) else $error("resumed");
endmodule
`default_nettype wire

// *** verification/test_adc_conversion_sequencer.sv ***
// Purpose: self-checking bench for the conversion sequencer
// Assumes: ack one cycle after a request, 20 MHz clock
// Notes: expected codes come from the bench's own level table
`timescale 1ns/10ps
`default_nettype none
`include "acs_defines.vh"
module test_adc_conversion_sequencer;
    logic clk_sys = 1'b0;
    logic resetn = 1'b0;
    logic wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0, standby = 1'b0;
    logic [3:0] wb_adr_i = 4'h0, wb_sel_i = 4'h0;
    logic [31:0] wb_dat_i = 32'h0;
    wire [31:0] wb_dat_o;
    wire wb_ack_o, analog_input_off_reg, ladder_on_reg, sample_reg, conv_done_irq;
    wire [2:0] channel_sel_reg;
    wire [9:0] adc_code;
    integer fail_count = 0, n_compared = 0, seed = 32'ha471, cyc_n = 0;
    integer i, t, t0, n;
    logic [9:0] lvl [0:7];
    logic [9:0] old;
    logic [2:0] ch;
    logic [7:0] q;
    // last entry is a reserved time code, run at the longest time
    logic [7:0] c2v [0:6] = '{8'h10, 8'h14, 8'h16, 8'h18, 8'h1a, 8'h1c,
        8'h12};
    integer tlen [0:6] = '{39, 78, 156, 312, 624, 1248, 1248};
    always #25 clk_sys = ~clk_sys;
    always @(posedge clk_sys) cyc_n <= cyc_n + 1;
    acs_sequencer u_acs_sequencer (.clk_sys(clk_sys), .resetn(resetn),
        .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
        .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
        .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .standby(standby),
        .adc_code(adc_code), .channel_sel_reg(channel_sel_reg),
        .analog_input_off_reg(analog_input_off_reg),
        .ladder_on_reg(ladder_on_reg), .sample_reg(sample_reg),
        .conv_done_irq(conv_done_irq));
    acs_analog_model u_acs_analog_model (.clk_sys(clk_sys),
        .channel_sel_reg(channel_sel_reg),
        .analog_input_off_reg(analog_input_off_reg), .adc_code(adc_code));
    task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        n_compared = n_compared + 1;
        if (g !== e) begin
            fail_count = fail_count + 1;
            $display("MISMATCH %s expected %h seen %h", nm, e, g);
        end
    endtask
    task bus(input logic [3:0] a, input logic w, input logic [7:0] d);
        integer k;
        @(posedge clk_sys);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i <= w;
        wb_adr_i <= a;
        wb_sel_i <= 4'hf;
        wb_dat_i <= {24'h0, d};
        k = 0;
        do begin
            @(posedge clk_sys);
            k = k + 1;
        end while (wb_ack_o !== 1'b1 && k < 20);
        chk("ack", 1, wb_ack_o);
        q = wb_dat_o[7:0];
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
    endtask
    task rd(input logic [3:0] a, input logic [7:0] m, input logic [7:0] e);
        bus(a, 1'b0, 8'h0);
        chk($sformatf("reg %h", a), e, q & m);
    endtask
    task wait_irq(input integer lim);
        n = 0;
        do begin
            @(posedge clk_sys);
            n = n + 1;
        end while (conv_done_irq !== 1'b1 && n < lim);
    endtask
    task give_verdict;
        $display("compared %0d mismatches %0d", n_compared, fail_count);
        if (fail_count == 0 && n_compared > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask
    initial begin
        repeat (30000) @(posedge clk_sys);
        fail_count = fail_count + 1;
        give_verdict;
    end
    initial begin
        for (i = 0; i < 8; i = i + 1) begin
            lvl[i] = 10'($random(seed));
            u_acs_analog_model.set_level(3'(i), lvl[i]);
        end
        repeat (16) @(posedge clk_sys);
        resetn <= 1'b1;
        rd(`ACS_OFF_CTRL1, 8'hff, 8'h10);
        rd(`ACS_OFF_CTRL2, 8'h3f, 8'h10);
        rd(4'h2, 8'hff, 8'h00);
        for (t = 0; t < 7; t = t + 1) begin
            ch = 3'($random(seed));
            bus(`ACS_OFF_CTRL2, 1'b1, c2v[t]);
            bus(`ACS_OFF_CTRL1, 1'b1, {5'h14, ch});
            t0 = cyc_n;
            rd(`ACS_OFF_CTRL1, 8'hff, {5'h04, ch});
            rd(`ACS_OFF_RES_LOW, 8'h30, 8'h10);
            chk("ladder", 1, ladder_on_reg);
            chk("channel", ch, channel_sel_reg);
            // no other bus traffic until the conversion ends
            wait_irq(1400);
            chk("sample", 1, sample_reg);
            chk("time", 1, cyc_n - t0 >= tlen[t] &&
                cyc_n - t0 <= tlen[t] + 6);
            rd(`ACS_OFF_RES_LOW, 8'hf0, {lvl[ch][1:0], 6'h20});
            rd(`ACS_OFF_RES_UP, 8'hff, lvl[ch][9:2]);
            rd(`ACS_OFF_RES_LOW, 8'h30, 8'h00);
            chk("ladder", 0, ladder_on_reg);
        end
        bus(`ACS_OFF_CTRL2, 1'b1, 8'h10);
        for (t = 0; t < 2; t = t + 1) begin
            bus(`ACS_OFF_CTRL1, 1'b1, {t[0] ? 5'h18 : 5'h10, ch});
            wait_irq(100);
            chk("idle", 100, n);
            rd(`ACS_OFF_RES_LOW, 8'h30, 8'h00);
        end
        bus(`ACS_OFF_CTRL1, 1'b1, {5'h14, ch});
        wait_irq(100);
        old = lvl[ch];
        lvl[ch] = ~old;
        u_acs_analog_model.set_level(ch, lvl[ch]);
        bus(`ACS_OFF_CTRL1, 1'b1, {5'h14, ch});
        rd(`ACS_OFF_RES_LOW, 8'hf0, {old[1:0], 6'h10});
        rd(`ACS_OFF_RES_UP, 8'hff, old[9:2]);
        wait_irq(100);
        rd(`ACS_OFF_RES_UP, 8'hff, lvl[ch][9:2]);
        // reserved channel code keeps the last valid channel
        bus(`ACS_OFF_CTRL1, 1'b1, {5'h15, ~ch});
        wait_irq(100);
        rd(`ACS_OFF_RES_UP, 8'hff, lvl[ch][9:2]);
        chk("channel", ch, channel_sel_reg);
        bus(`ACS_OFF_CTRL1, 1'b1, {5'h1c, ch});
        wait_irq(100);
        t0 = cyc_n;
        wait_irq(100);
        chk("gap", 1, cyc_n - t0 >= 39 && cyc_n - t0 <= 45);
        u_acs_analog_model.set_level(ch, ~lvl[ch]);
        repeat (10) @(posedge clk_sys);
        bus(`ACS_OFF_CTRL1, 1'b1, {5'h00, ch});
        wait_irq(100);
        chk("halt", 100, n);
        rd(`ACS_OFF_RES_UP, 8'hff, lvl[ch][9:2]);
        bus(`ACS_OFF_CTRL2, 1'b1, 8'h30);
        bus(`ACS_OFF_CTRL1, 1'b1, {5'h14, ch});
        repeat (5) @(posedge clk_sys);
        chk("ladder", 1, ladder_on_reg);
        standby <= 1'b1;
        repeat (5) @(posedge clk_sys);
        chk("ladder", 0, ladder_on_reg);
        standby <= 1'b0;
        wait_irq(100);
        chk("resume", 100, n);
        rd(`ACS_OFF_CTRL1, 8'hff, 8'h10);
        rd(`ACS_OFF_CTRL2, 8'h3f, 8'h10);
        rd(`ACS_OFF_RES_LOW, 8'h30, 8'h00);
        give_verdict;
    end
endmodule
bind acs_sequencer acs_sequencer_chk u_acs_sequencer_chk (.clk_sys(clk_sys),
    .resetn(resetn), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .standby(standby),
    .channel_sel_reg(channel_sel_reg), .analog_input_off_reg(analog_input_off_reg),
    .ladder_on_reg(ladder_on_reg), .sample_reg(sample_reg),
    .conv_done_irq(conv_done_irq));
`default_nettype wire
